// ### cmbg_alu.sv
// Sixteen-bit parallel arithmetic unit with result condition flags.
// Assumes operands are held stable by the caller; purely combinational.
`timescale 1ns/1ps
module cmbg_alu
	import cmbg_pkg::*;
(
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire cmbg_op_t          op,
	output logic      [DATA_W-1:0] result,
	output cmbg_flags_t            flags
);

	// ---------------------------------------------------------------
	// Datapath
	// ---------------------------------------------------------------
	logic [DATA_W:0] wide;
	logic [DATA_W:0] diff;

	// One adder used by add, one subtractor used by subtract and by the carry flag of every other operation
	always_comb
	begin
		diff = {1'b0, a} - {1'b0, b};
		wide = {1'b0, a} + {1'b0, b};
		unique case (op)
			OP_ADD:  result = wide[DATA_W-1:0];
			OP_SUB:  result = diff[DATA_W-1:0];
			OP_AND:  result = a & b;
			OP_OR:   result = a | b;
			OP_XOR:  result = a ^ b;
			OP_CMP:  result = a;
			OP_PASS: result = b;
			default: result = a;
		endcase
	end

	// Greater-than flags compare the operand pair; equal (outside compare) and overflow look at the result
	always_comb
	begin
		flags.logical_gt = a > b;
		flags.arith_gt   = $signed(a) > $signed(b);
		flags.equal      = (op == OP_CMP) ? (a == b) : (result == DATA_RST);
		flags.carry      = (op == OP_ADD) ? wide[DATA_W] : ~diff[DATA_W];
		flags.overflow   = (op == OP_ADD) ? ((a[DATA_W-1] == b[DATA_W-1]) && (result[DATA_W-1] != a[DATA_W-1]))
		                 : ((a[DATA_W-1] != b[DATA_W-1]) && (result[DATA_W-1] != a[DATA_W-1]));
	end

endmodule // cmbg_alu

// ### cmbg_bus.sv
// Processor external bus sequencer, bus takeover, interrupt sampling and core registers.
// Assumes pin inputs arrive asynchronously; the wire level is resolved from the enables outside.
`timescale 1ns/1ps
module cmbg_bus
	import cmbg_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// Core side request and answer
	input  wire logic                   req_valid,
	input  wire cmbg_req_t              req,
	output logic                        req_ready,
	output logic                        rsp_valid,
	output logic       [DATA_W-1:0]     rsp_rdata,
	input  wire logic                   fetch,
	// Core registers
	input  wire logic                   wp_load,
	input  wire logic  [ADDR_W-1:0]     wp_value,
	output logic       [ADDR_W-1:0]     workspace_ptr,
	input  wire logic                   pc_load,
	input  wire logic                   pc_inc,
	input  wire logic  [ADDR_W-1:0]     pc_value,
	output logic       [ADDR_W-1:0]     program_counter,
	input  wire logic                   alu_go,
	input  wire cmbg_op_t               alu_op,
	input  wire logic  [DATA_W-1:0]     alu_a,
	input  wire logic  [DATA_W-1:0]     alu_b,
	output logic       [DATA_W-1:0]     alu_result,
	output cmbg_flags_t                 status_flags,
	input  wire logic  [INSTR_IDX_W-1:0] instr_index,
	output logic                        instr_legal,
	output logic                        irq_pending,
	output logic       [LEVEL_W-1:0]    irq_level,
	// Pins
	output logic       [ADDR_W-1:0]     addr_out,
	output logic                        addr_oe_n,
	input  wire logic  [DATA_W-1:0]     data_in,
	output logic       [DATA_W-1:0]     data_out,
	output logic                        data_oe_n,
	output logic                        memory_enable_n,
	output logic                        write_strobe_n,
	output logic                        read_direction,
	output logic                        ctl_oe_n,
	output logic                        bus_takeover_grant,
	output logic                        wait_out,
	output logic                        instruction_fetch_flag,
	input  wire logic                   ready,
	input  wire logic                   bus_takeover_req_n,
	input  wire logic                   interrupt_request_n,
	input  wire logic  [LEVEL_W-1:0]    interrupt_level_code,
	input  wire logic                   serial_io_in,
	output logic                        serial_io_out,
	output logic                        serial_io_strobe
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int SYNC_W = DATA_W + LEVEL_W + 4;

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [DATA_W-1:0] data_s;
	logic [LEVEL_W-1:0] level_s;
	logic              ready_s;
	logic              hold_s;
	logic              interrupt_request_n_s;
	logic              serial_s;

	// Two stages on every pin; data rides along so it lines up with ready
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end
		else
		begin
			sync1_reg <= {data_in, interrupt_level_code, ready, bus_takeover_req_n, interrupt_request_n, serial_io_in};
			sync2_reg <= sync1_reg;
		end
	end

	assign data_s   = sync2_reg[SYNC_W-1 -: DATA_W];
	assign level_s  = sync2_reg[4 +: LEVEL_W];
	assign ready_s  = sync2_reg[3];
	assign hold_s   = ~sync2_reg[2];
	assign interrupt_request_n_s = ~sync2_reg[1];
	assign serial_s = sync2_reg[0];

	// ---------------------------------------------------------------
	// Bus sequencer
	// ---------------------------------------------------------------
	cmbg_state_t state_reg;
	cmbg_state_t state_next;
	cmbg_req_t   req_reg;
	logic        fetch_reg;

	// Takeover is only taken between cycles, never inside one
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (hold_s) state_next = ST_HOLD;
			         else if (req_valid) state_next = req.serial ? ST_IO : ST_MEM;
			ST_MEM:  state_next = ready_s ? ST_DONE : ST_WAIT;
			ST_WAIT: if (ready_s) state_next = ST_DONE;
			ST_IO:   state_next = ST_DONE;
			ST_DONE: state_next = hold_s ? ST_HOLD : ST_IDLE;
			ST_HOLD: if (!hold_s) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Request is held for the whole cycle so address and data stay stable
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			req_reg   <= '0;
			fetch_reg <= 1'b0;
		end
		else if (state_reg == ST_IDLE && !hold_s && req_valid)
		begin
			req_reg   <= req;
			fetch_reg <= fetch & ~req.serial;
		end
	end

	assign req_ready = (state_reg == ST_IDLE) && !hold_s;

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	logic in_mem;

	assign in_mem = (state_reg == ST_MEM) || (state_reg == ST_WAIT);

	// Registered address and write data; memory or serial address by enable
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			addr_out <= ADDR_RST;
			data_out <= DATA_RST;
		end
		else if (state_reg == ST_IDLE && !hold_s && req_valid)
		begin
			addr_out <= req.addr;
			data_out <= req.wdata;
		end
	end

	// Everything floats while the grant stands
	assign addr_oe_n          = (state_reg == ST_HOLD);
	assign ctl_oe_n           = (state_reg == ST_HOLD);
	assign data_oe_n          = !(in_mem && req_reg.write);
	assign memory_enable_n    = !in_mem;
	assign write_strobe_n     = !(in_mem && req_reg.write);
	assign read_direction     = in_mem && !req_reg.write;
	assign bus_takeover_grant = (state_reg == ST_HOLD);
	assign wait_out           = (state_reg == ST_WAIT);
	assign instruction_fetch_flag = in_mem && fetch_reg;
	assign serial_io_out      = req_reg.wdata[0];
	assign serial_io_strobe   = (state_reg == ST_IO) && req_reg.write;

	// Answer: read word from the bus or serial bit, one pulse per cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= DATA_RST;
		end
		else
		begin
			rsp_valid <= (state_reg == ST_DONE);
			if (state_reg == ST_DONE && !req_reg.write)
				rsp_rdata <= req_reg.serial ? {{(DATA_W-1){1'b0}}, serial_s} : data_s;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt sampling
	// ---------------------------------------------------------------
	// Level code is only meaningful while the request is active
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			irq_pending <= 1'b0;
			irq_level   <= LEVEL_RST;
		end
		else
		begin
			irq_pending <= interrupt_request_n_s;
			if (interrupt_request_n_s)
				irq_level <= level_s;
		end
	end

	// ---------------------------------------------------------------
	// Core registers
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] alu_res_c;
	cmbg_flags_t       alu_flags_c;

	cmbg_alu u_alu (
		.a      (alu_a),
		.b      (alu_b),
		.op     (alu_op),
		.result (alu_res_c),
		.flags  (alu_flags_c)
	);

	// Workspace pointer
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			workspace_ptr <= ADDR_RST;
		else if (wp_load)
			workspace_ptr <= wp_value;
	end

	// Program counter; load beats increment
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			program_counter <= ADDR_RST;
		else if (pc_load)
			program_counter <= pc_value;
		else if (pc_inc)
			program_counter <= program_counter + PC_STEP;
	end

	// Result and status flags latched per operation
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			alu_result   <= DATA_RST;
			status_flags <= FLAGS_RST;
		end
		else if (alu_go)
		begin
			alu_result   <= alu_res_c;
			status_flags <= alu_flags_c;
		end
	end

	// Decoder legality by instruction word index
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			instr_legal <= 1'b0;
		else
			instr_legal <= instr_index < INSTR_WORD_COUNT;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_grant_floats_addr: assert property (bus_takeover_grant |-> addr_oe_n && ctl_oe_n)
		else $error("address or strobes driven under grant");
	a_grant_floats_data: assert property (bus_takeover_grant |-> data_oe_n && memory_enable_n)
		else $error("data driven under grant");
	a_mem_addr_stable: assert property (!memory_enable_n |-> addr_out == req_reg.addr && !addr_oe_n)
		else $error("memory address not driven");
	a_read_strobes: assert property (read_direction |-> !memory_enable_n && write_strobe_n && data_oe_n)
		else $error("bad read strobes");
	a_write_strobes: assert property (!write_strobe_n |-> !memory_enable_n && !read_direction && !data_oe_n)
		else $error("bad write strobes");
	a_data_only_mem: assert property (!data_oe_n |-> !memory_enable_n)
		else $error("data driven outside memory cycle");
	a_wait_until_ready: assert property ((state_reg == ST_MEM || wait_out) && !ready_s |=> wait_out)
		else $error("wait not held");
	a_wait_ends: assert property (wait_out && ready_s |=> !wait_out ##1 rsp_valid)
		else $error("cycle not completed after ready");
	a_grant_after_cycle: assert property (in_mem |-> !bus_takeover_grant)
		else $error("grant inside memory cycle");
	a_grant_follows: assert property (state_reg == ST_IDLE && hold_s |=> bus_takeover_grant)
		else $error("takeover not granted");
	a_pc_step: assert property (pc_inc && !pc_load |=> program_counter == $past(program_counter) + PC_STEP)
		else $error("program counter did not step");
	a_flags_equal: assert property (alu_go && alu_op == OP_CMP && alu_a == alu_b |=> status_flags.equal)
		else $error("equal flag missing");

	c_read_wait: cover property (state_reg == ST_MEM && !req_reg.write ##1 wait_out ##[1:20] rsp_valid);
	c_write: cover property (!write_strobe_n ##[1:4] rsp_valid);
	c_takeover: cover property (bus_takeover_grant ##1 !bus_takeover_grant);
	c_serial_out: cover property (serial_io_strobe);

endmodule // cmbg_bus

// ### cmbg_mem_model.sv
// Console memory partner: 128-word scratch store with adjustable wait states.
// Assumes the pin side of cmbg_bus, all sampled on the rising edge of clk_sys.
`timescale 1ns/1ps
module cmbg_mem_model
	import cmbg_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [3:0]        stall,
	input  wire logic [ADDR_W-1:0] addr_out,
	input  wire logic              memory_enable_n,
	input  wire logic              write_strobe_n,
	input  wire logic              read_direction,
	input  wire logic              ctl_oe_n,
	input  wire logic [DATA_W-1:0] data_out,
	output logic      [DATA_W-1:0] data_in,
	output logic                   ready
);
	logic [DATA_W-1:0] mem_reg [0:127];
	logic [3:0]        cnt_reg;
	logic [DATA_W-1:0] last_reg;
	logic              sel;
	logic              rdy_reg;

	// Selected only in a driven memory cycle; a floating enable reads as the pulled-up idle level
	assign sel = !ctl_oe_n && (memory_enable_n === 1'b0);

	// Ready drops with the select, so no stale ready leaks into the next cycle
	assign ready = rdy_reg && sel;

	// Ready stays low until the data has settled, so the synced ready never outruns it
	always_ff @(posedge clk_sys)
	begin
		if (rst || !sel)
		begin
			cnt_reg <= 4'h0;
			rdy_reg <= 1'b0;
		end
		else
		begin
			if (cnt_reg != 4'hF)
				cnt_reg <= cnt_reg + 4'h1;
			rdy_reg <= (cnt_reg >= stall);
			if (!write_strobe_n)
				mem_reg[addr_out[6:0]] <= data_out;
		end
	end

	// Released data lines show the inverse of the last value, never a held copy
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			last_reg <= 16'h0000;
		else
			last_reg <= data_in;
	end
	assign data_in = (sel && read_direction) ? mem_reg[addr_out[6:0]] : ~last_reg;
endmodule // cmbg_mem_model

// ### cmbg_pkg.sv
// Shared constants, state codes and bundles of the processor bus interface.
// Assumes one clock clk_sys and a synchronous active-high reset.
//
// Contract
// - Address lines carry memory or serial addresses
// - Address lines float while takeover granted
// - Data bus moves words only during enable
// - Data lines float while takeover granted
// - Read asserts direction and enable, no write
// - Direction high only with data buffers off
// - Sixteen-bit parallel ALU does arithmetic, compare
// - Workspace pointer and program counter kept
// - Status flags record results for tests
// - Decoder accepts sixty-nine instruction words
// - Not ready stretches cycle, wait asserted
// - Write asserts enable and strobe, direction low
// - Takeover granted only after current cycle
package cmbg_pkg;

	// ---------------------------------------------------------------
	// Widths and counts
	// ---------------------------------------------------------------
	localparam int ADDR_W          = 15;
	localparam int DATA_W          = 16;
	localparam int LEVEL_W         = 4;
	localparam int INSTR_IDX_W     = 7;
	localparam logic [INSTR_IDX_W-1:0] INSTR_WORD_COUNT = 7'h45; // Sixty-nine words

	// ---------------------------------------------------------------
	// Reset values and program counter step
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0]  ADDR_RST   = 15'h0000;
	localparam logic [DATA_W-1:0]  DATA_RST   = 16'h0000;
	localparam logic [LEVEL_W-1:0] LEVEL_RST  = 4'hF;
	localparam logic [ADDR_W-1:0]  PC_STEP    = 15'h0001;

	// ---------------------------------------------------------------
	// Bus sequencer states, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_MEM  = 6'h02,
		ST_WAIT = 6'h04,
		ST_DONE = 6'h08,
		ST_IO   = 6'h10,
		ST_HOLD = 6'h20
	} cmbg_state_t;

	// ---------------------------------------------------------------
	// Arithmetic operations
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_ADD  = 3'h0,
		OP_SUB  = 3'h1,
		OP_AND  = 3'h2,
		OP_OR   = 3'h3,
		OP_XOR  = 3'h4,
		OP_CMP  = 3'h5,
		OP_PASS = 3'h6
	} cmbg_op_t;

	// Bus request from the core side
	typedef struct packed {
		logic              write;
		logic              serial;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmbg_req_t;

	// Result condition flags
	typedef struct packed {
		logic logical_gt;
		logic arith_gt;
		logic equal;
		logic carry;
		logic overflow;
	} cmbg_flags_t;

	localparam cmbg_flags_t FLAGS_RST = 5'h00;

endpackage

// ### testbench.sv
// Self-checking bench for the processor bus block and its core registers.
// Assumes cmbg_bus as design top and cmbg_mem_model on its memory pins.
`timescale 1ns/1ps
module testbench;
	import cmbg_pkg::*;
	logic                   clk_sys, rst, req_valid, fetch, req_ready, rsp_valid;
	cmbg_req_t              req;
	logic [DATA_W-1:0]      rsp_rdata, alu_a, alu_b, alu_result, data_in, data_out;
	logic                   wp_load, pc_load, pc_inc, alu_go, instr_legal, irq_pending;
	logic [ADDR_W-1:0]      wp_value, workspace_ptr, pc_value, program_counter, addr_out;
	cmbg_op_t               alu_op;
	cmbg_flags_t            status_flags;
	logic [INSTR_IDX_W-1:0] instr_index;
	logic [LEVEL_W-1:0]     irq_level, interrupt_level_code;
	logic                   addr_oe_n, data_oe_n, memory_enable_n, write_strobe_n, read_direction, ctl_oe_n;
	logic                   bus_takeover_grant, wait_out, instruction_fetch_flag, ready, bus_takeover_req_n;
	logic                   interrupt_request_n, serial_io_in, serial_io_out, serial_io_strobe;
	logic [3:0]             stall;
	logic [9:0]             seen;
	int                     n_fail, checks_done;
	logic                   fetch_or_grant;

	// Console glue: fetch flag and grant combined on one line
	assign fetch_or_grant = instruction_fetch_flag | bus_takeover_grant;

	cmbg_bus dut_u (.clk_sys, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .fetch,
		.wp_load, .wp_value, .workspace_ptr, .pc_load, .pc_inc, .pc_value, .program_counter,
		.alu_go, .alu_op, .alu_a, .alu_b, .alu_result, .status_flags, .instr_index, .instr_legal,
		.irq_pending, .irq_level, .addr_out, .addr_oe_n, .data_in, .data_out, .data_oe_n,
		.memory_enable_n, .write_strobe_n, .read_direction, .ctl_oe_n, .bus_takeover_grant,
		.wait_out, .instruction_fetch_flag, .ready, .bus_takeover_req_n, .interrupt_request_n,
		.interrupt_level_code, .serial_io_in, .serial_io_out, .serial_io_strobe);
	cmbg_mem_model mem_u (.clk_sys, .rst, .stall, .addr_out, .memory_enable_n, .write_strobe_n,
		.read_direction, .ctl_oe_n, .data_out, .data_in, .ready);

	// Clock at 125 MHz
	always #4 clk_sys = ~clk_sys;

	// Compare and count
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One core bus cycle; seen collects what the pins showed while it ran
	task automatic bus_op(input logic wr, ser, input logic [14:0] a, input logic [15:0] wd,
		input logic fe, hold_mid, output logic [15:0] rd, output int n);
		n = 0;
		seen = 10'h000;
		req_valid = 1'b1;
		req = '{write: wr, serial: ser, addr: a, wdata: wd};
		fetch = fe;
		do @(negedge clk_sys); while (req_ready !== 1'b1);
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		if (hold_mid)
			bus_takeover_req_n = 1'b0;
		while (rsp_valid !== 1'b1 && n < 60)
		begin
			seen |= {read_direction === 1'b1 && data_oe_n === 1'b0, data_oe_n === 1'b0 && data_out !== wd,
				(memory_enable_n === 1'b0 || serial_io_strobe === 1'b1) && addr_out !== a,
				bus_takeover_grant === 1'b1 && rsp_valid !== 1'b1, serial_io_strobe === 1'b1,
				instruction_fetch_flag === 1'b1, wait_out === 1'b1, read_direction === 1'b1,
				write_strobe_n === 1'b0, memory_enable_n === 1'b0};
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("answer", 16'h0001, {15'h0000, rsp_valid});
		rd = rsp_rdata;
	endtask

	// Memory write, fetch read back, then a plain read and a stretched read
	task automatic t_mem();
		logic [15:0] rd;
		int n0, n4;
		bus_op(1'b1, 1'b0, 15'h0023, 16'hA5C3, 1'b0, 1'b0, rd, n0);
		chk("write pins", 16'h0003, {6'h00, seen & 10'h3F7});
		bus_op(1'b0, 1'b0, 15'h0023, 16'h0000, 1'b1, 1'b0, rd, n0);
		chk("read pins", 16'h0015, {6'h00, seen & 10'h3F7});
		chk("read word", 16'hA5C3, rd);
		bus_op(1'b0, 1'b0, 15'h0023, 16'h0000, 1'b0, 1'b0, rd, n0);
		stall = 4'h4;
		bus_op(1'b0, 1'b0, 15'h0023, 16'h0000, 1'b0, 1'b0, rd, n4);
		chk("stretch", 16'h0004, 16'(n4 - n0));
		chk("wait seen", 16'h0001, {15'h0000, seen[3]});
		chk("slow word", 16'hA5C3, rd);
		$display("test memory done");
	endtask

	// Serial bit out and in, memory enable left inactive
	task automatic t_serial();
		logic [15:0] rd;
		int n;
		bus_op(1'b1, 1'b1, 15'h0102, 16'h0001, 1'b0, 1'b0, rd, n);
		chk("serial write pins", 16'h0020, {6'h00, seen & 10'h3F7});
		chk("serial out", 16'h0001, {15'h0000, serial_io_out});
		serial_io_in = 1'b1;
		bus_op(1'b0, 1'b1, 15'h0104, 16'h0000, 1'b0, 1'b0, rd, n);
		chk("serial read pins", 16'h0000, {6'h00, seen & 10'h3F7});
		chk("serial in", 16'h0001, {15'h0000, rd[0]});
		$display("test serial done");
	endtask

	// Wait a bounded time for the grant to reach a level
	task automatic wait_grant(input logic v);
		for (int i = 0; i < 20 && bus_takeover_grant !== v; i++)
		begin
			@(posedge clk_sys);
			#1;
		end
		chk("grant", {15'h0000, v}, {15'h0000, bus_takeover_grant});
	endtask

	// Takeover asked in mid-cycle: the cycle finishes first, then all pins float
	task automatic t_hold();
		logic [15:0] rd;
		int n;
		stall = 4'h2;
		bus_op(1'b0, 1'b0, 15'h0023, 16'h0000, 1'b0, 1'b1, rd, n);
		chk("early grant", 16'h0000, {15'h0000, seen[6]});
		chk("held word", 16'hA5C3, rd);
		wait_grant(1'b1);
		chk("floated", 16'h0007, {13'h0000, addr_oe_n, data_oe_n, ctl_oe_n});
		chk("fetch or grant", 16'h0001, {15'h0000, fetch_or_grant});
		@(negedge clk_sys);
		chk("refused", 16'h0000, {15'h0000, req_ready});
		@(posedge clk_sys);
		#1;
		bus_takeover_req_n = 1'b1;
		wait_grant(1'b0);
		chk("driven again", 16'h0000, {14'h0000, addr_oe_n, ctl_oe_n});
		$display("test takeover done");
	endtask

	// One arithmetic operation, registered on the go pulse
	task automatic alu_run(input cmbg_op_t op, input logic [15:0] a, b);
		alu_op = op;
		alu_a = a;
		alu_b = b;
		alu_go = 1'b1;
		@(posedge clk_sys);
		#1;
		alu_go = 1'b0;
	endtask

	// Core registers, arithmetic, decoder limit and interrupt sampling
	task automatic t_core();
		cmbg_op_t    ops [5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
		logic [15:0] exp [5] = '{16'h00E0, 16'hE100, 16'h00F0, 16'hFFF0, 16'hFF00};
		pc_load = 1'b1;
		wp_load = 1'b1;
		instr_index = 7'h44;
		@(posedge clk_sys);
		#1;
		pc_load = 1'b0;
		wp_load = 1'b0;
		pc_inc = 1'b1;
		instr_index = 7'h45;
		chk("workspace", 16'h0200, {1'b0, workspace_ptr});
		chk("legal last", 16'h0001, {15'h0000, instr_legal});
		@(posedge clk_sys);
		#1;
		pc_inc = 1'b0;
		chk("counter", 16'h1001, {1'b0, program_counter});
		chk("beyond last", 16'h0000, {15'h0000, instr_legal});
		for (int i = 0; i < 5; i++)
		begin
			alu_run(ops[i], 16'hF0F0, 16'h0FF0);
			chk("alu result", exp[i], alu_result);
		end
		alu_run(OP_ADD, 16'hFFFF, 16'h0001);
		chk("add flags", 16'h0003, {14'h0000, status_flags.equal, status_flags.carry});
		alu_run(OP_CMP, 16'h1234, 16'h1234);
		chk("cmp equal", 16'h0001, {15'h0000, status_flags.equal});
		alu_run(OP_CMP, 16'h1234, 16'h1235);
		chk("cmp differ", 16'h0000, {15'h0000, status_flags.equal});
		interrupt_request_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("irq pending", 16'h0001, {15'h0000, irq_pending});
		chk("irq level", 16'h0001, {12'h000, irq_level});
		interrupt_request_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("irq cleared", 16'h0000, {15'h0000, irq_pending});
		$display("test core done");
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog well beyond the expected run of under a hundred cycles
	initial
	begin
		#200000;
		n_fail++;
		$display("Error watchdog expected done seen hang");
		final_report();
	end

	// Reset, then the scenarios in order
	initial
	begin
		{clk_sys, req_valid, fetch, wp_load, pc_load, pc_inc, alu_go, serial_io_in} = 8'h00;
		{rst, bus_takeover_req_n, interrupt_request_n} = 3'h7; // Reset asserted; takeover request and interrupt request lines idle high
		req = '0;
		{alu_a, alu_b} = 32'h00000000;
		alu_op = OP_ADD;
		wp_value = 15'h0200;
		pc_value = 15'h1000;
		instr_index = 7'h00;
		interrupt_level_code = 4'h1;
		stall = 4'h0;
		repeat (8) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_mem();
		t_serial();
		t_hold();
		t_core();
		final_report();
	end
endmodule // testbench
